// *** hw/pdps_pd_decode.v ***
`timescale 1ns/100ps
`include "pdps_defines.vh"

// ----------------------------------------------------------------
// decodes one port D 2-bit mode field into a pad function select
// ----------------------------------------------------------------
module pdps_pd_decode (
    mode,
    narrow_bus,
    sel
);
    input wire [1:0] mode; // stored field value
    input wire narrow_bus; // area 0 in 8-bit mode
    output reg [1:0] sel; // resulting pad function

    // combinational decode; prohibited codes fall back to port
    always @* begin
        sel = `PDPS_SEL_PORT;
        if (narrow_bus) begin
            case (mode)
                `PDPS_PD_DATA: sel = `PDPS_SEL_DATA;
                `PDPS_PD_TIMER: sel = `PDPS_SEL_TIMER;
                default: sel = `PDPS_SEL_PORT;
            endcase
        end else begin
            // wide bus: only data is legal
            if (mode == `PDPS_PD_DATA) begin
                sel = `PDPS_SEL_DATA;
            end else begin
                sel = `PDPS_SEL_PORT;
            end
        end
    end
endmodule

// *** hw/pdps_top.v ***
`timescale 1ns/100ps
`include "pdps_defines.vh"

module pdps_top #(
    parameter PE_PINS = 17
) (
    clock,
    sys_rst,
    narrow_bus,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    pd_sel,
    pe16_cs_sel,
    pe_dir_valid,
    pe_oe
);
    input wire clock; // 50 MHz system clock
    input wire sys_rst; // power-on reset, synchronous, high
    input wire narrow_bus; // area 0 8-bit strap (mode pins)
    input wire [`PDPS_ADDR_W-1:0] reg_addr; // register index
    input wire [15:0] reg_wdata; // write data
    input wire reg_wr; // write strobe
    input wire reg_rd; // read strobe
    output reg [15:0] reg_rdata; // read data, cycle after strobe
    output reg [15:0] pd_sel; // 2-bit function per pin 15..8
    output reg pe16_cs_sel; // pin 16 driven by chip select 8
    input wire [PE_PINS-1:0] pe_dir_valid; // pin in port/timer function
    output reg [PE_PINS-1:0] pe_oe; // pad output enable

    // ----------------------------------------------------------------
    // strap synchroniser
    // ----------------------------------------------------------------
    reg narrow_meta_q; // first stage
    reg narrow_q; // synchronised strap

    // two flops on the mode strap, it comes from a pin
    always @(posedge clock) begin
        if (sys_rst) begin
            narrow_meta_q <= 1'b0;
            narrow_q <= 1'b0;
        end else begin
            narrow_meta_q <= narrow_bus;
            narrow_q <= narrow_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [15:0] pd_hi_q; // pins 15..12 mode select
    reg [15:0] pd_lo_q; // pins 11..8 mode select
    reg [15:0] pe_dir_hi_q; // pin 16 direction
    reg [15:0] pe_dir_lo_q; // pins 15..0 direction
    reg [15:0] pe16_mode_q; // pin 16 mode select
    reg init_pend_q; // port D still awaits strap-based load
    reg [1:0] init_cnt_q; // waits out the synchroniser

    // write path; reserved bits masked off so they read zero
    always @(posedge clock) begin
        if (sys_rst) begin
            pd_hi_q <= `PDPS_RST_ZERO;
            pd_lo_q <= `PDPS_RST_ZERO;
            pe_dir_hi_q <= `PDPS_RST_ZERO;
            pe_dir_lo_q <= `PDPS_RST_ZERO;
            pe16_mode_q <= `PDPS_RST_ZERO;
            init_pend_q <= 1'b1;
            init_cnt_q <= 2'h0;
        end else begin
            if (init_pend_q) begin
                // strap caught after release once synchronised
                if (init_cnt_q == 2'h2) begin
                    init_pend_q <= 1'b0;
                    pd_hi_q <= narrow_q ? `PDPS_RST_PD_NARROW : `PDPS_RST_PD_WIDE;
                    pd_lo_q <= narrow_q ? `PDPS_RST_PD_NARROW : `PDPS_RST_PD_WIDE;
                end else begin
                    init_cnt_q <= init_cnt_q + 2'h1;
                end
            end
            if (reg_wr) begin
                case (reg_addr)
                    `PDPS_OFS_PD_15_12: pd_hi_q <= reg_wdata & `PDPS_PD_FIELD_MASK;
                    `PDPS_OFS_PD_11_8: pd_lo_q <= reg_wdata & `PDPS_PD_FIELD_MASK;
                    `PDPS_OFS_PE_DIR_HI: pe_dir_hi_q <= reg_wdata & `PDPS_PE_DIR_HI_MASK;
                    `PDPS_OFS_PE_DIR_LO: pe_dir_lo_q <= reg_wdata;
                    `PDPS_OFS_PE16_MODE: pe16_mode_q <= reg_wdata & `PDPS_PE16_MODE_MASK;
                    default: init_cnt_q <= init_cnt_q;
                endcase
            end
        end
    end

    // read path; unmapped index reads zero
    always @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `PDPS_OFS_PD_15_12: reg_rdata <= pd_hi_q;
                `PDPS_OFS_PD_11_8: reg_rdata <= pd_lo_q;
                `PDPS_OFS_PE_DIR_HI: reg_rdata <= pe_dir_hi_q;
                `PDPS_OFS_PE_DIR_LO: reg_rdata <= pe_dir_lo_q;
                `PDPS_OFS_PE16_MODE: reg_rdata <= pe16_mode_q;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // port D function decode
    // ----------------------------------------------------------------
    wire [31:0] pd_fields; // fields packed pin 15 down to pin 8
    wire [15:0] pd_sel_d; // decoded selects
    assign pd_fields = {pd_hi_q, pd_lo_q};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pd
            // field for pin 8+gi sits at bits 4*gi+1:4*gi of the pair
            pdps_pd_decode u_dec (
                .mode(pd_fields[4*gi+1:4*gi]),
                .narrow_bus(narrow_q),
                .sel(pd_sel_d[2*gi+1:2*gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // port E direction and pin 16 function
    // ----------------------------------------------------------------
    wire pe16_is_cs; // pin 16 chip select chosen
    wire pe16_is_port; // pin 16 general port (incl. prohibited)
    wire [PE_PINS-1:0] pe_dir_all; // direction bits, pin 16 on top
    assign pe16_is_cs = (pe16_mode_q[2:0] == `PDPS_PE16_CS8);
    assign pe16_is_port = ~pe16_is_cs;
    assign pe_dir_all = {pe_dir_hi_q[0], pe_dir_lo_q[PE_PINS-2:0]};

    // registered outputs
    always @(posedge clock) begin
        if (sys_rst) begin
            pd_sel <= 16'h0000;
            pe16_cs_sel <= 1'b0;
            pe_oe <= {PE_PINS{1'b0}};
        end else begin
            pd_sel <= pd_sel_d;
            pe16_cs_sel <= pe16_is_cs;
            // direction honoured only in port or timer function
            pe_oe[PE_PINS-2:0] <= pe_dir_all[PE_PINS-2:0]
                & pe_dir_valid[PE_PINS-2:0];
            pe_oe[PE_PINS-1] <= pe_dir_all[PE_PINS-1] & pe16_is_port;
        end
    end
endmodule

// *** inc/pdps_defines.vh ***
`ifndef PDPS_DEFINES_VH
`define PDPS_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------
`define PDPS_ADDR_W 3
`define PDPS_OFS_PD_15_12 3'h0
`define PDPS_OFS_PD_11_8 3'h1
`define PDPS_OFS_PE_DIR_HI 3'h2
`define PDPS_OFS_PE_DIR_LO 3'h3
`define PDPS_OFS_PE16_MODE 3'h4

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define PDPS_PD_FIELD_MASK 16'h3333
`define PDPS_RST_PD_WIDE 16'h1111
`define PDPS_RST_PD_NARROW 16'h0000
`define PDPS_RST_ZERO 16'h0000
`define PDPS_PE_DIR_HI_MASK 16'h0001
`define PDPS_PE16_MODE_MASK 16'h0007

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define PDPS_PD_PORT 2'h0
`define PDPS_PD_DATA 2'h1
`define PDPS_PD_TIMER 2'h3
`define PDPS_PE16_PORT 3'h0
`define PDPS_PE16_CS8 3'h5

// ----------------------------------------------------------------
// pin function select encoding driven to the pad
// ----------------------------------------------------------------
`define PDPS_SEL_PORT 2'h0
`define PDPS_SEL_DATA 2'h1
`define PDPS_SEL_TIMER 2'h2
`define PDPS_SEL_OTHER 2'h3

`endif

// *** sim/pdps_mux_model.sv ***
`timescale 1ns/100ps
// other pin muxes: flags pins in port or timer use
module pdps_mux_model (
    input wire clock,
    input wire [16:0] pick,
    output reg [16:0] pe_dir_valid = 17'h0
);
    // a new choice lands one edge later
    always @(posedge clock) pe_dir_valid <= pick;
endmodule

// *** sim/pdps_props.sv ***
`timescale 1ns/100ps
module pdps_props #(parameter PE_PINS = 17) (
    input wire clock,
    input wire sys_rst,
    input wire narrow_bus,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [15:0] pd_sel,
    input wire pe16_cs_sel,
    input wire [PE_PINS-1:0] pe_dir_valid,
    input wire [PE_PINS-1:0] pe_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("rdata not idle");
    pd_rsv_a: assert property ($past(reg_rd) && $past(reg_addr) < 3'h2 |->
        (reg_rdata & 16'hcccc) == 16'h0) else $error("pd reserved set");
    dir_hi_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h2 |->
        reg_rdata[15:1] == 15'h0) else $error("dir high reserved set");
    pin16_rsv_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h4 |->
        reg_rdata[15:3] == 13'h0) else $error("pin16 reserved set");
    oe_gate_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) &&
        $past(reg_wr, 2) && $past(reg_addr, 2) == 3'h3 |-> pe_oe[15:0] ==
        ($past(reg_wdata, 2) & $past(pe_dir_valid[15:0]))) else $error("oe mismatch");
    oe_off_a: assert property ((pe_oe[15:0] & ~$past(pe_dir_valid[15:0])) == 16'h0)
        else $error("oe without function");
    cs_oe_a: assert property (pe16_cs_sel |-> !pe_oe[16])
        else $error("pin16 oe in cs");
    wide_pd_a: assert property ((!narrow_bus) [*6] |-> (pd_sel & 16'haaaa) == 16'h0)
        else $error("wide mode not data");
endmodule
bind pdps_top pdps_props #(.PE_PINS(PE_PINS)) chk (.*);

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clock = 1'b0, sys_rst = 1'b1, narrow_bus = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic pe16_cs_sel;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, pd_sel;
    logic [16:0] pick = 17'h0, pe_dir_valid, pe_oe, e;
    logic [31:0] lfsr = 32'h3922e264;
    int num_errors = 0, n_tests = 0, c, mdl [0:5];
    int msk [0:4] = '{16'h3333, 16'h3333, 16'h1, 16'hffff, 16'h7};
    initial forever #10 clock = ~clock;
    pdps_top dut (.*);
    pdps_mux_model far (.*);
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    // one write or read cycle; read data checked in the cycle after
    task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        if (w && a < 5) mdl[a] = d & msk[a];
        if (!w) begin
            @(posedge clock);
            `CHK("reg_rdata", mdl[a], reg_rdata)
        end
    endtask
    // pad outputs once the last write has settled
    task automatic chk_out();
        repeat (3) @(posedge clock);
        for (int p = 0; p < 8; p++) begin
            c = mdl[p < 4] >> (p % 4 * 4) & 3;
            e[2*p +: 2] = c == 1 ? 2'h1 : c == 3 && narrow_bus ? 2'h2 : 2'h0;
        end
        `CHK("pd_sel", e[15:0], pd_sel)
        `CHK("pe16_cs_sel", (mdl[4] & 7) == 5, pe16_cs_sel)
        e = {mdl[2][0] & (mdl[4] & 7) != 5, mdl[3][15:0] & pick[15:0]};
        `CHK("pe_oe", e, pe_oe)
    endtask
    initial begin
        for (int m = 0; m < 2; m++) begin
            sys_rst <= 1'b1;
            narrow_bus <= m[0];
            repeat (6) @(posedge clock);
            sys_rst <= 1'b0;
            mdl = '{m ? 0 : 16'h1111, m ? 0 : 16'h1111, 0, 0, 0, 0};
            repeat (4) @(posedge clock);
            for (int a = 0; a < 6; a++) bus(1'b0, 3'(a), 16'h0);
            // every pin16 code and every port D code
            for (int k = 0; k < 8; k++) begin
                bus(1'b1, 3'h4, 16'(k));
                bus(1'b1, 3'(k % 2), 16'h1111 * 16'(k / 2));
                chk_out();
            end
            // random traffic, unmapped index included
            for (int k = 0; k < 40; k++) begin
                lfsr = step(lfsr);
                pick <= lfsr[16:0];
                bus(1'b1, lfsr[31:29] % 3'h6, lfsr[15:0]);
                bus(1'b0, lfsr[28:26] % 3'h6, 16'h0);
                chk_out();
            end
        end
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("%0d checks %0d errors", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
endmodule
